// file: dpie_engine.sv
// Instruction engine with its output byte buffer
`timescale 1ns/10ps

module dpie_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_in, // Clock
    input wire logic srst_in, // Sync reset
    input wire logic [WIDTH-1:0] wdata_in, // Write data
    input wire logic wvalid_in, // Write valid
    output logic wready_out, // Not full
    output logic [WIDTH-1:0] rdata_out, // Head data
    output logic rvalid_out, // Not empty
    input wire logic rready_in // Drain
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic do_w;
    logic do_r;
    assign wready_out = (cnt_reg != (AW+1)'(DEPTH));
    assign rvalid_out = (cnt_reg != '0);
    assign do_w = wvalid_in && wready_out;
    assign do_r = rvalid_out && rready_in;
    assign rdata_out = mem_reg[rp_reg];
    always_ff @(posedge clk_in) begin
        if (do_w) begin
            mem_reg[wp_reg] <= wdata_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_w) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (do_r) begin
                rp_reg <= rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(do_w) - (AW+1)'(do_r);
        end
    end
endmodule // dpie_fifo

module dpie_engine
    import dpie_pkg::*;
(
    input wire logic clk_in, // 250 MHz clock
    input wire logic srst_in, // Sync reset, high
    input wire logic link_clk_in, // Programmer link clock pin
    input wire logic [7:0] rx_data_in, // Received byte
    input wire logic rx_valid_in, // Received byte strobe (link domain)
    input wire logic rx_error_in, // Parity/frame/collision level
    input wire logic rx_break_in, // Break seen level
    output logic [7:0] tx_data_out, // Byte to send
    output logic tx_valid_out, // Byte available
    input wire logic tx_ready_in, // Transmitter takes byte
    output logic [31:0] bus_addr_out, // Internal bus address
    output logic [7:0] bus_wdata_out, // Internal bus write data
    output logic bus_wr_out, // Internal bus write pulse
    output logic bus_rd_out, // Internal bus read pulse
    input wire logic [7:0] bus_rdata_in, // Read data, next cycle
    output logic [3:0] cs_addr_out, // Control space address
    output logic [7:0] cs_wdata_out, // Control space write data
    output logic cs_wr_out, // Control space write pulse
    output logic cs_rd_out, // Control space read pulse
    input wire logic [7:0] cs_rdata_in, // Control space read data
    output logic key_ok_out, // Memory programming enabled
    input wire logic key_clear_in, // Disable memory programming
    output logic error_out // Engine in error state
);
    // Link clock three flops, strobes and data two flops each
    logic [2:0] lclk_sync_reg;
    logic [1:0] rxv_sync_reg;
    logic [1:0] err_sync_reg;
    logic [1:0] brk_sync_reg;
    logic [7:0] rxd_meta_reg;
    logic [7:0] rxd_sync_reg;
    logic [7:0] rxd_reg;
    logic rx_stb_reg;
    logic lclk_rise;
    logic rx_stb;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lclk_sync_reg <= 3'h0;
            rxv_sync_reg <= 2'h0;
            err_sync_reg <= 2'h0;
            brk_sync_reg <= 2'h0;
            rxd_meta_reg <= 8'h0;
            rxd_sync_reg <= 8'h0;
            rxd_reg <= 8'h0;
            rx_stb_reg <= 1'b0;
        end else begin
            lclk_sync_reg <= {lclk_sync_reg[1:0], link_clk_in};
            rxv_sync_reg <= {rxv_sync_reg[0], rx_valid_in};
            err_sync_reg <= {err_sync_reg[0], rx_error_in};
            brk_sync_reg <= {brk_sync_reg[0], rx_break_in};
            rxd_meta_reg <= rx_data_in;
            rxd_sync_reg <= rxd_meta_reg;
            // Byte settled 80 ns before the rising edge
            rx_stb_reg <= lclk_rise && rxv_sync_reg[1];
            if (lclk_rise) begin
                rxd_reg <= rxd_sync_reg;
            end
        end
    end
    assign lclk_rise = lclk_sync_reg[1] && !lclk_sync_reg[2];
    // One strobe per rising link edge with valid high, in the same cycle the byte is first held
    assign rx_stb = rx_stb_reg;

    dpie_state_e state_reg;
    logic [7:0] ir_reg;
    logic [PTR_W-1:0] ptr_reg;
    logic [PTR_W-1:0] rpt_reg;
    logic [2:0] cnt_reg;
    logic [63:0] key_reg;
    logic [7:0] out_byte;
    logic out_push;
    logic fifo_ready;
    logic rd_pend_reg;
    logic rd_cs_reg;
    logic [2:0] opc;
    logic [1:0] asz;
    logic [1:0] dsz;
    logic [1:0] pmode;
    logic [7:0] rbyte;
    logic last_data;
    logic more_rpt;

    assign opc = ir_reg[OPC_HI:OPC_LO];
    assign asz = ir_reg[SZA_HI:SZA_LO];
    assign dsz = ir_reg[SZD_HI:SZD_LO];
    assign pmode = ir_reg[SZA_HI:SZA_LO];
    assign last_data = (cnt_reg == {1'b0, dsz});
    assign more_rpt = (rpt_reg != RPT_RST);
    assign rbyte = rd_cs_reg ? cs_rdata_in : bus_rdata_in;
    assign out_byte = (state_reg == S_RPTR) ?
        ptr_reg[8*cnt_reg[1:0] +: 8] : rbyte;
    assign out_push = rd_pend_reg || (state_reg == S_RPTR && fifo_ready);
    assign error_out = (state_reg == S_ERROR);

    dpie_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_txq (
        .clk_in(clk_in),
        .srst_in(srst_in || error_out),
        .wdata_in(out_byte),
        .wvalid_in(out_push),
        .wready_out(fifo_ready),
        .rdata_out(tx_data_out),
        .rvalid_out(tx_valid_out),
        .rready_in(tx_ready_in)
    );

    // Decide where a freshly taken instruction goes
    function automatic dpie_state_e first_state(input logic [7:0] ins);
        case (ins[OPC_HI:OPC_LO])
            OP_DIRECT_LOAD, OP_DIRECT_STORE: first_state = S_ADDR;
            OP_INDIRECT_LOAD: first_state =
                (ins[SZA_HI:SZA_LO] == PM_PTR) ? S_RPTR : S_RBUS;
            OP_INDIRECT_STORE: first_state =
                (ins[SZA_HI:SZA_LO] == PM_PTR) ? S_WPTR : S_DATA;
            OP_CS_LOAD: first_state = S_CS_RD;
            OP_CS_STORE: first_state = S_CS_WR;
            OP_REPEAT: first_state = S_COUNT;
            default: first_state = S_KEY;
        endcase
    endfunction

    // Sequencer: one byte per step, reads issued when room exists
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= S_IDLE;
            ir_reg <= IR_RST;
            cnt_reg <= CNT_RST;
            rd_pend_reg <= 1'b0;
            rd_cs_reg <= 1'b0;
        end else begin
            rd_pend_reg <= bus_rd_out || cs_rd_out;
            rd_cs_reg <= cs_rd_out;
            if (err_sync_reg[1] && state_reg != S_ERROR) begin
                state_reg <= S_ERROR;
            end else begin
                case (state_reg)
                    S_ERROR: begin
                        if (brk_sync_reg[1]) begin
                            state_reg <= S_IDLE;
                        end
                    end
                    S_IDLE: begin
                        if (rx_stb) begin
                            ir_reg <= rxd_reg;
                            cnt_reg <= CNT_RST;
                            state_reg <= first_state(rxd_reg);
                        end else if (more_rpt && opc != OP_REPEAT &&
                                opc != OP_KEY) begin
                            cnt_reg <= CNT_RST;
                            state_reg <= first_state(ir_reg);
                        end
                    end
                    S_ADDR: begin
                        if (rx_stb) begin
                            cnt_reg <= cnt_reg + 3'h1;
                            if (cnt_reg == {1'b0, asz}) begin
                                cnt_reg <= CNT_RST;
                                state_reg <= (opc == OP_DIRECT_LOAD) ?
                                    S_RBUS : S_DATA;
                            end
                        end
                    end
                    S_DATA, S_WPTR, S_COUNT: begin
                        if (rx_stb) begin
                            cnt_reg <= cnt_reg + 3'h1;
                            if (last_data) begin
                                state_reg <= S_IDLE;
                            end
                        end
                    end
                    S_RBUS, S_RPTR: begin
                        if (fifo_ready && !rd_pend_reg) begin
                            cnt_reg <= cnt_reg + 3'h1;
                            if (last_data) begin
                                state_reg <= S_IDLE;
                            end
                        end
                    end
                    S_KEY: begin
                        if (rx_stb && rpt_reg[2:0] == KEY_LAST) begin
                            state_reg <= S_IDLE;
                        end
                    end
                    S_CS_RD: begin
                        if (fifo_ready) begin
                            state_reg <= S_IDLE;
                        end
                    end
                    S_CS_WR: begin
                        if (rx_stb) begin
                            state_reg <= S_IDLE;
                        end
                    end
                    default: state_reg <= S_IDLE;
                endcase
            end
        end
    end

    // Bus strobes: one single-byte access per step
    logic data_step;
    assign data_step = (state_reg == S_RBUS) && fifo_ready && !rd_pend_reg;
    always_comb begin
        bus_rd_out = data_step && !error_out;
        bus_wr_out = (state_reg == S_DATA) && rx_stb;
        cs_rd_out = (state_reg == S_CS_RD) && fifo_ready;
        cs_wr_out = (state_reg == S_CS_WR) && rx_stb;
    end
    assign bus_addr_out = ptr_reg;
    assign bus_wdata_out = rxd_reg;
    assign cs_addr_out = ir_reg[CSA_HI:CSA_LO];
    assign cs_wdata_out = rxd_reg;

    // Pointer: address operands, pointer writes, post-increment
    logic inc_now;
    assign inc_now = (opc == OP_INDIRECT_LOAD || opc == OP_INDIRECT_STORE) &&
        pmode == PM_DATA_INC && (bus_rd_out || bus_wr_out);
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ptr_reg <= PTR_RST;
        end else if (rx_stb && (state_reg == S_ADDR ||
                state_reg == S_WPTR)) begin
            ptr_reg[8*cnt_reg[1:0] +: 8] <= rxd_reg;
        end else if (inc_now) begin
            ptr_reg <= ptr_reg + 32'h1;
        end else if ((opc == OP_DIRECT_LOAD || opc == OP_DIRECT_STORE) &&
                (bus_rd_out || bus_wr_out) && !last_data) begin
            ptr_reg <= ptr_reg + 32'h1;
        end
    end

    // Repeat counter: loaded by repeat, cleared by key, counts down
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rpt_reg <= RPT_RST;
        end else if (state_reg == S_ERROR) begin
            rpt_reg <= RPT_RST;
        end else if (state_reg == S_IDLE && rx_stb) begin
            if (rxd_reg[OPC_HI:OPC_LO] == OP_KEY) begin
                rpt_reg <= RPT_RST;
            end
        end else if (state_reg == S_IDLE && more_rpt &&
                opc != OP_REPEAT && opc != OP_KEY) begin
            rpt_reg <= rpt_reg - 32'h1;
        end else if (state_reg == S_COUNT && rx_stb) begin
            if (cnt_reg == CNT_RST) begin
                rpt_reg <= {24'h0, rxd_reg};
            end else begin
                rpt_reg[8*cnt_reg[1:0] +: 8] <= rxd_reg;
            end
        end else if (state_reg == S_KEY && rx_stb) begin
            // Key count must not leave a repeat behind
            if (rpt_reg[2:0] == KEY_LAST) begin
                rpt_reg <= RPT_RST;
            end else begin
                rpt_reg <= rpt_reg + 32'h1;
            end
        end
    end

    // Key shift and check, first byte least significant
    logic key_done;
    assign key_done = state_reg == S_KEY && rx_stb &&
        rpt_reg[2:0] == KEY_LAST;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            key_reg <= 64'h0;
            key_ok_out <= 1'b0;
        end else begin
            if (state_reg == S_KEY && rx_stb) begin
                key_reg <= {rxd_reg, key_reg[63:8]};
            end
            if (key_done && {rxd_reg, key_reg[63:8]} == KEY_VALUE) begin
                key_ok_out <= 1'b1;
            end else if (key_clear_in) begin
                key_ok_out <= 1'b0;
            end
        end
    end
endmodule // dpie_engine

// file: dpie_pkg.sv
// Package for the debug port instruction engine
package dpie_pkg;
    localparam int BYTE_W = 8;
    localparam int PTR_W = 32;
    localparam int FIFO_DEPTH = 8;
    // Instruction byte layout: opcode [7:5], fields [3:2] and [1:0]
    localparam logic [2:0] OP_DIRECT_LOAD = 3'h0;
    localparam logic [2:0] OP_INDIRECT_LOAD = 3'h1;
    localparam logic [2:0] OP_DIRECT_STORE = 3'h2;
    localparam logic [2:0] OP_INDIRECT_STORE = 3'h3;
    localparam logic [2:0] OP_CS_LOAD = 3'h4;
    localparam logic [2:0] OP_REPEAT = 3'h5;
    localparam logic [2:0] OP_CS_STORE = 3'h6;
    localparam logic [2:0] OP_KEY = 3'h7;
    localparam int OPC_HI = 7;
    localparam int OPC_LO = 5;
    localparam int CSA_HI = 3;
    localparam int CSA_LO = 0;
    localparam int SZA_HI = 3;
    localparam int SZA_LO = 2;
    localparam int SZD_HI = 1;
    localparam int SZD_LO = 0;
    // Indirect pointer modes in bits [3:2]
    localparam logic [1:0] PM_DATA = 2'h0;
    localparam logic [1:0] PM_DATA_INC = 2'h1;
    localparam logic [1:0] PM_PTR = 2'h2;
    localparam logic [63:0] KEY_VALUE = 64'h1289ab45cdd888ff;
    localparam logic [2:0] KEY_LAST = 3'h7;
    localparam logic [PTR_W-1:0] PTR_RST = 32'h0;
    localparam logic [PTR_W-1:0] RPT_RST = 32'h0;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [7:0] IR_RST = 8'h0;
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [2:0] OUT_BYTE = 3'h4;
    localparam logic [2:0] OUT_PTR = 3'h5;
    typedef struct packed {
        logic [BYTE_W-1:0] data;
    } dpie_byte_s;
    typedef struct packed {
        logic [PTR_W-1:0] addr;
        logic [BYTE_W-1:0] wdata;
        logic wr;
        logic ctrl;
    } dpie_bus_s;
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_DATA, S_RBUS, S_RPTR, S_WPTR,
        S_COUNT, S_KEY, S_CS_RD, S_CS_WR, S_ERROR
    } dpie_state_e;
endpackage

// file: dpie_prog_model.sv
// Programmer-side link model: link clock and received bytes
`timescale 1ns/10ps

module dpie_prog_model (
    input wire logic clk_in, // Bench clock for pacing
    output logic link_clk_out, // Link clock, still between bytes
    output logic [7:0] rx_data_out, // Byte from programmer
    output logic rx_valid_out // High 160 ns per byte, across its rising link edge
);
    initial begin
        link_clk_out = 1'b0;
        rx_data_out = 8'h00;
        rx_valid_out = 1'b0;
    end
    // One whole byte per call, 260 ns link period
    task automatic send(input logic [7:0] b);
        @(posedge clk_in);
        #1;
        rx_data_out = b;
        rx_valid_out = 1'b1;
        repeat (20) @(posedge clk_in);
        #1 link_clk_out = 1'b1;
        repeat (20) @(posedge clk_in);
        #1 link_clk_out = 1'b0;
        rx_valid_out = 1'b0;
        rx_data_out = ~b; // Stale byte never repeats
        repeat (24) @(posedge clk_in);
    endtask
endmodule // dpie_prog_model

// file: dpie_engine_properties.sv
// Port timing checker for the instruction engine
`timescale 1ns/10ps

module dpie_engine_properties (
    input wire logic clk_in, // Clock
    input wire logic srst_in, // Sync reset
    input wire logic rx_error_in, // Link fault
    input wire logic rx_break_in, // Break seen
    input wire logic tx_valid_out, // Byte available
    input wire logic tx_ready_in, // Byte taken
    input wire logic [7:0] tx_data_out, // Byte to send
    input wire logic [31:0] bus_addr_out, // Bus address
    input wire logic bus_wr_out, // Bus write
    input wire logic bus_rd_out, // Bus read
    input wire logic cs_wr_out, // Control write
    input wire logic cs_rd_out, // Control read
    input wire logic key_ok_out, // Programming enabled
    input wire logic key_clear_in, // Disable request
    input wire logic error_out // Error state
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    a_bus_single: assert property (!(bus_wr_out && bus_rd_out))
        else $error("bus read and write together");
    a_cs_ptr_kept: assert property ((cs_wr_out || cs_rd_out) |->
        $stable(bus_addr_out)) else $error("pointer moved on control access");
    a_cs_wr_alone: assert property (cs_wr_out |->
        !bus_wr_out && !bus_rd_out && !cs_rd_out)
        else $error("control write mixed with other access");
    a_cs_rd_alone: assert property (cs_rd_out |->
        !bus_wr_out && !bus_rd_out) else $error("control read mixed");
    a_err_quiet: assert property (error_out |->
        !bus_wr_out && !bus_rd_out && !cs_wr_out && !cs_rd_out)
        else $error("access while in error");
    a_err_entry: assert property ($rose(rx_error_in) |->
        ##[1:10] error_out) else $error("fault did not raise error");
    a_break_exit: assert property (error_out && rx_break_in &&
        !rx_error_in |-> ##[1:10] !error_out)
        else $error("break did not leave error");
    a_key_drop: assert property (key_clear_in && key_ok_out |->
        ##[1:4] !key_ok_out) else $error("key enable not cleared");
    a_tx_hold: assert property (tx_valid_out && !tx_ready_in &&
        !error_out |=> error_out || (tx_valid_out && $stable(tx_data_out)))
        else $error("output byte lost while stalled");
    c_write: cover property (bus_wr_out);
    c_key: cover property ($rose(key_ok_out));
    c_error: cover property ($rose(error_out));
    c_stall: cover property (tx_valid_out && !tx_ready_in);
endmodule // dpie_engine_properties

bind dpie_engine dpie_engine_properties u_props (.clk_in, .srst_in,
    .rx_error_in, .rx_break_in, .tx_valid_out, .tx_ready_in, .tx_data_out,
    .bus_addr_out, .bus_wr_out, .bus_rd_out, .cs_wr_out, .cs_rd_out,
    .key_ok_out, .key_clear_in, .error_out);

// file: test_dpie_engine.sv
// Self-checking bench for the debug port instruction engine
`timescale 1ns/10ps

module test_dpie_engine
    import dpie_pkg::*;
;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic link_clk, rx_valid, tx_valid, bus_wr, bus_rd, cs_wr, cs_rd;
    logic key_ok, err, rd_q, crd_q;
    logic rx_error = 1'b0;
    logic rx_break = 1'b0;
    logic tx_ready = 1'b1;
    logic key_clear = 1'b0;
    logic [7:0] rx_data, tx_data, bus_wdata, cs_wdata, c;
    logic [7:0] bus_rdata = 8'h00;
    logic [7:0] cs_rdata = 8'h00;
    logic [31:0] bus_addr, p, w, d, ra_q;
    logic [3:0] cs_addr, ca_q;
    logic [7:0] cs_mem [16];
    logic [40:0] wq [$];
    logic [40:0] tq [$];
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    always #2 clk_in = ~clk_in;
    dpie_prog_model pm (.clk_in(clk_in), .link_clk_out(link_clk),
        .rx_data_out(rx_data), .rx_valid_out(rx_valid));
    dpie_engine dut (.clk_in(clk_in), .srst_in(srst_in),
        .link_clk_in(link_clk), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
        .rx_error_in(rx_error), .rx_break_in(rx_break),
        .tx_data_out(tx_data), .tx_valid_out(tx_valid),
        .tx_ready_in(tx_ready), .bus_addr_out(bus_addr),
        .bus_wdata_out(bus_wdata), .bus_wr_out(bus_wr), .bus_rd_out(bus_rd),
        .bus_rdata_in(bus_rdata), .cs_addr_out(cs_addr),
        .cs_wdata_out(cs_wdata), .cs_wr_out(cs_wr), .cs_rd_out(cs_rd),
        .cs_rdata_in(cs_rdata), .key_ok_out(key_ok),
        .key_clear_in(key_clear), .error_out(err));
    function automatic logic [7:0] rd_val(input logic [31:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    function automatic logic [40:0] pop_w();
        return wq.size() > 0 ? wq.pop_front() : 'x;
    endfunction
    function automatic logic [40:0] pop_t();
        return tq.size() > 0 ? tq.pop_front() : 'x;
    endfunction
    task automatic chk(input logic [40:0] got, input logic [40:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic settle();
        for (int i = 0; i < 900 && wq.size() + tq.size() > 0; i++)
            @(posedge clk_in);
        chk(41'(wq.size() + tq.size()), 41'h0);
    endtask
    task automatic send_word(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) pm.send(v[8*i +: 8]);
    endtask
    task automatic exp_rd(input logic [31:0] a, input int n);
        for (int i = 0; i < n; i++) tq.push_back({33'h0, rd_val(a + i)});
    endtask
    // Result monitor, plus bus and control space responders
    always @(negedge clk_in) begin
        if (bus_wr) chk({1'b0, bus_addr, bus_wdata}, pop_w());
        if (cs_wr) chk({1'b1, 28'h0, cs_addr, cs_wdata}, pop_w());
        if (cs_wr) cs_mem[cs_addr] = cs_wdata;
        if (tx_valid && tx_ready) chk({33'h0, tx_data}, pop_t());
        rd_q = bus_rd;
        ra_q = bus_addr;
        crd_q = cs_rd;
        ca_q = cs_addr;
        @(posedge clk_in);
        #1;
        bus_rdata = rd_q ? rd_val(ra_q) : ~bus_rdata;
        cs_rdata = crd_q ? cs_mem[ca_q] : ~cs_rdata;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(32'h9b966f8d));
        repeat (6) @(posedge clk_in);
        #1 srst_in = 1'b0;
        p = $urandom();
        for (int i = 0; i < 4; i++) tq.push_back({33'h0, p[8*i +: 8]});
        pm.send({OP_INDIRECT_STORE, 1'b0, PM_PTR, 2'h3});
        send_word(p, 4);
        pm.send({OP_INDIRECT_LOAD, 1'b0, PM_PTR, 2'h3});
        settle();
        w = $urandom() & 32'hff7e;
        d = $urandom();
        p = {p[31:16], w[15:0]};
        wq.push_back({1'b0, p, d[7:0]});
        wq.push_back({1'b0, p + 32'h1, d[15:8]});
        pm.send({OP_DIRECT_STORE, 1'b0, 2'h1, 2'h1});
        send_word(w, 2);
        send_word(d, 2);
        settle();
        w = $urandom() & 32'hf8;
        p = {p[31:8], w[7:0]};
        exp_rd(p, 4);
        pm.send({OP_DIRECT_LOAD, 1'b0, 2'h0, 2'h3});
        send_word(w, 1);
        settle();
        p = $urandom() & 32'hffffff70;
        pm.send({OP_INDIRECT_STORE, 1'b0, PM_PTR, 2'h3});
        send_word(p, 4);
        c = 8'($urandom());
        wq.push_back({1'b1, 28'h0, 4'h2, c});
        tq.push_back({33'h0, c});
        pm.send({OP_CS_STORE, 5'h2});
        pm.send(c);
        pm.send({OP_CS_LOAD, 5'h2});
        d = $urandom();
        for (int i = 0; i < 3; i++) wq.push_back({1'b0, p + i, d[8*i +: 8]});
        pm.send({OP_REPEAT, 5'h0});
        send_word(32'h2, 1);
        pm.send({OP_INDIRECT_STORE, 1'b0, PM_DATA_INC, 2'h0});
        send_word(d, 3);
        exp_rd(p + 32'h3, 1);
        pm.send({OP_INDIRECT_LOAD, 1'b0, PM_DATA_INC, 2'h0});
        settle();
        // Ten reads against a stalled transmitter fill the buffer
        @(posedge clk_in);
        #1 tx_ready = 1'b0;
        exp_rd(p + 32'h4, 10);
        pm.send({OP_REPEAT, 5'h0});
        send_word(32'h9, 1);
        pm.send({OP_INDIRECT_LOAD, 1'b0, PM_DATA_INC, 2'h0});
        repeat (100) @(posedge clk_in);
        #1;
        chk({40'h0, tx_valid}, 41'h1);
        tx_ready = 1'b1;
        settle();
        pm.send({OP_KEY, 5'h0});
        send_word(KEY_VALUE[31:0], 4);
        send_word(KEY_VALUE[63:32], 4);
        for (int i = 0; i < 50 && key_ok !== 1'b1; i++) @(posedge clk_in);
        chk({40'h0, key_ok}, 41'h1);
        @(posedge clk_in);
        #1 key_clear = 1'b1;
        repeat (4) @(posedge clk_in);
        #1 key_clear = 1'b0;
        chk({40'h0, key_ok}, 41'h0);
        rx_error = 1'b1;
        repeat (12) @(posedge clk_in);
        #1 rx_error = 1'b0;
        chk({40'h0, err}, 41'h1);
        pm.send({OP_CS_STORE, 5'h2});
        pm.send(~c);
        @(posedge clk_in);
        #1 rx_break = 1'b1;
        repeat (20) @(posedge clk_in);
        #1 rx_break = 1'b0;
        chk({40'h0, err}, 41'h0);
        tq.push_back({33'h0, c});
        pm.send({OP_CS_LOAD, 5'h2});
        settle();
        end_of_test();
    end
endmodule // test_dpie_engine
